// *** logic/twm_pkg.sv ***
// Shared constants and types of the two-wire master transmitter
package twm_pkg;
    // Register byte addresses
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;
    localparam logic [3:0] ADR_DATA = 4'h8;
    // Bit positions in bus_control_reg
    localparam int CB_DONE = 7;
    localparam int CB_ACKEN = 6;
    localparam int CB_START = 5;
    localparam int CB_STOP = 4;
    localparam int CB_WCOL = 3;
    localparam int CB_EN = 2;
    localparam int CB_IRQEN = 0;
    // Status codes, prescaler field at zero
    localparam logic [7:0] SC_START = 8'h08;
    localparam logic [7:0] SC_RESTART = 8'h10;
    localparam logic [7:0] SC_AW_ACK = 8'h18;
    localparam logic [7:0] SC_AW_NACK = 8'h20;
    localparam logic [7:0] SC_D_ACK = 8'h28;
    localparam logic [7:0] SC_D_NACK = 8'h30;
    localparam logic [7:0] SC_ARB = 8'h38;
    localparam logic [7:0] SC_AR_ACK = 8'h40;
    localparam logic [7:0] SC_AR_NACK = 8'h48;
    localparam logic [7:0] SC_IDLE = 8'hf8;
    localparam logic [7:0] DATA_RST = 8'hff;
    // System clock cycles per quarter of a bus bit
    localparam int QUARTER_DEF = 2;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_WAIT = 3'b001,
        PH_START = 3'b010,
        PH_SEND = 3'b011,
        PH_ACK = 3'b100,
        PH_STOP = 3'b101,
        PH_HOLD = 3'b110
    } twm_phase_t;

    typedef struct packed {
        twm_phase_t phase;
        logic done;
        logic acken;
        logic sta;
        logic sto;
        logic wcol;
        logic en;
        logic irqen;
        logic [4:0] code;
        logic [7:0] data;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic [1:0] qc;
        logic [7:0] div;
        logic scl_oe_n;
        logic sda_oe_n;
        logic busy;
        logic own;
        logic addr_phase;
        logic rw;
        logic nack;
        logic recv_mode;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic ack;
        logic [31:0] rdat;
    } twm_state_t;

    localparam twm_state_t STATE_RST = '{
        phase: PH_IDLE, code: 5'h1f, data: 8'hff, scl_oe_n: 1'b1,
        sda_oe_n: 1'b1, sync1: 2'h3, sync2: 2'h3, prev: 2'h3,
        default: '0};
endpackage

// *** logic/twm_master.sv ***
// Two-wire bus master transmitter with a classic Wishbone register slave
// What this block does
// - Write address enters master send mode; read address enters receive.
// - Status codes assume prescaler zero; software masks prescaler before compare.
// - Step-done flag clears only on writing one; writing zero does nothing.
// - After a START request, wait for a free bus, then send START.
// - Once START is sent, set step-done and report code 0x08.
// - After address and ack: 0x18 ack, 0x20 no ack, 0x38 lost.
// - Data writes only while done is high; else discard, set collision.
// - In 0x18..0x30 clearing done with start=stop=0 sends the data byte.
// - After a data byte report 0x28 on ack, 0x30 on no ack.
// - In 0x18..0x30 clearing done with start=1, stop=0 sends repeated START.
// - Clearing done with stop=1 sends STOP; hardware then clears stop bit.
// - Clearing done with start=1, stop=1 sends STOP then a new START.
// - After repeated START set done and report 0x10; readdress allowed.
// - In 0x10 write address keeps send mode; read address enters receive.
// - Arbitration loss reports 0x38; clearing done, start=0 releases the bus.
// - In 0x38 clearing done with start=1 sends START once bus frees.
// - While done is set all bus activity is suspended, state held.
//
// The address map and the Wishbone interface to the registers were left to the implementer.

`timescale 1ns/1ps
module twm_master #(
    parameter int QUARTER_CYCLES = twm_pkg::QUARTER_DEF
) (
    input wire logic CLK_SYS_I, // System clock
    input wire logic RSTN_I, // Asynchronous reset, active low
    input wire logic WB_CYC_I, // Wishbone cycle
    input wire logic WB_STB_I, // Wishbone strobe
    input wire logic WB_WE_I, // Wishbone write enable
    input wire logic [3:0] WB_ADR_I, // Wishbone byte address
    input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
    input wire logic [31:0] WB_DAT_I, // Wishbone write data
    output logic [31:0] WB_DAT_O, // Wishbone read data
    output logic WB_ACK_O, // Wishbone acknowledge
    input wire logic SCL_I, // Bus clock line level
    output logic SCL_O, // Bus clock drive value
    output logic SCL_OE_N_O, // Bus clock drive enable, low drives
    input wire logic SDA_I, // Bus data line level
    output logic SDA_O, // Bus data drive value
    output logic SDA_OE_N_O // Bus data drive enable, low drives
);
    localparam logic [7:0] QMAX = 8'(QUARTER_CYCLES - 1);

    twm_pkg::twm_state_t s;
    twm_pkg::twm_state_t n;
    // Combinational helpers
    logic scl_h;
    logic sda_h;
    logic tick;
    logic wr;
    logic lost;

    always_comb begin
        n = s;
        // The second stage and prev, one cycle older, are read by logic
        n.sync1 = {SCL_I, SDA_I};
        n.sync2 = s.sync1;
        n.prev = s.sync2;
        scl_h = s.sync2[1];
        sda_h = s.sync2[0];
        lost = 1'b0;
        // Free-bus watch from START and STOP seen on the wires
        if (scl_h && s.prev[1] && s.prev[0] && !sda_h) begin
            n.busy = 1'b1;
        end else if (scl_h && s.prev[1] && !s.prev[0] && sda_h) begin
            n.busy = 1'b0;
        end

        // Quarter-bit pacing, free running
        tick = (s.div == QMAX);
        n.div = tick ? 8'h00 : s.div + 8'h01;

        // Classic Wishbone: answer one cycle after the request
        n.ack = WB_CYC_I && WB_STB_I && !s.ack;
        // Read data registered so it stands in the ack cycle
        case (WB_ADR_I)
            twm_pkg::ADR_CTRL: n.rdat = {24'h0, s.done, s.acken, s.sta,
                s.sto, s.wcol, s.en, 1'b0, s.irqen};
            twm_pkg::ADR_STAT: n.rdat = {24'h0, s.code, 3'b000};
            twm_pkg::ADR_DATA: n.rdat = {24'h0, s.data};
            default: n.rdat = 32'h0;
        endcase

        // Writes land at the edge that ends the ack cycle
        wr = WB_CYC_I && WB_STB_I && WB_WE_I && s.ack && WB_SEL_I[0];
        if (wr && WB_ADR_I == twm_pkg::ADR_CTRL) begin
            if (WB_DAT_I[twm_pkg::CB_DONE]) begin
                n.done = 1'b0;
            end
            n.acken = WB_DAT_I[twm_pkg::CB_ACKEN];
            n.sta = WB_DAT_I[twm_pkg::CB_START];
            n.sto = WB_DAT_I[twm_pkg::CB_STOP];
            n.en = WB_DAT_I[twm_pkg::CB_EN];
            n.irqen = WB_DAT_I[twm_pkg::CB_IRQEN];
        end

        if (wr && WB_ADR_I == twm_pkg::ADR_DATA) begin
            if (s.done) begin
                n.data = WB_DAT_I[7:0];
                n.wcol = 1'b0;
            end else begin
                n.wcol = 1'b1;
            end
        end

        case (s.phase)
            // Lines released until a START is asked for
            twm_pkg::PH_IDLE: begin
                n.scl_oe_n = 1'b1;
                n.sda_oe_n = 1'b1;
                n.own = 1'b0;
                if (s.en && s.sta) begin
                    n.phase = twm_pkg::PH_WAIT;
                end
            end

            // Hold off while another master owns the bus
            twm_pkg::PH_WAIT: begin
                if (!s.busy && tick) begin
                    n.phase = twm_pkg::PH_START;
                    n.qc = 2'd0;
                end
            end

            // Data falls while the clock is high
            twm_pkg::PH_START: begin
                if (tick) begin
                    n.qc = s.qc + 2'd1;
                    case (s.qc)
                        2'd0: n.sda_oe_n = 1'b1;
                        2'd1: n.scl_oe_n = 1'b1;
                        2'd2: begin
                            if (scl_h) begin
                                n.sda_oe_n = 1'b0;
                            end else begin
                                n.qc = s.qc; // Clock held low by a slave
                            end
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.code = s.own ? twm_pkg::SC_RESTART[7:3]
                                : twm_pkg::SC_START[7:3];
                            n.own = 1'b1;
                            n.addr_phase = 1'b1;
                            n.recv_mode = 1'b0;
                            n.done = 1'b1;
                            n.phase = twm_pkg::PH_HOLD;
                        end
                    endcase
                end
            end

            // MSB first; only released bits can lose arbitration
            twm_pkg::PH_SEND: begin
                if (tick) begin
                    n.qc = s.qc + 2'd1;
                    case (s.qc)
                        2'd0: n.sda_oe_n = s.shift[7];
                        2'd1: n.scl_oe_n = 1'b1;
                        2'd2: begin
                            if (!scl_h) begin
                                n.qc = s.qc;
                            end else if (s.shift[7] && !sda_h) begin
                                lost = 1'b1;
                            end
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.shift = {s.shift[6:0], 1'b0};
                            n.bitcnt = s.bitcnt + 3'd1;
                            if (s.bitcnt == 3'd7) begin
                                n.phase = twm_pkg::PH_ACK;
                            end
                        end
                    endcase
                end
            end

            // Ninth clock: slave answer sampled with clock high
            twm_pkg::PH_ACK: begin
                if (tick) begin
                    n.qc = s.qc + 2'd1;
                    case (s.qc)
                        2'd0: n.sda_oe_n = 1'b1;
                        2'd1: n.scl_oe_n = 1'b1;
                        2'd2: begin
                            if (scl_h) begin
                                n.nack = sda_h;
                            end else begin
                                n.qc = s.qc;
                            end
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.done = 1'b1;
                            n.phase = twm_pkg::PH_HOLD;
                            n.addr_phase = 1'b0;
                            if (s.addr_phase && s.rw) begin
                                n.recv_mode = 1'b1;
                                n.code = s.nack ? twm_pkg::SC_AR_NACK[7:3]
                                    : twm_pkg::SC_AR_ACK[7:3];
                            end else if (s.addr_phase) begin
                                n.code = s.nack ? twm_pkg::SC_AW_NACK[7:3]
                                    : twm_pkg::SC_AW_ACK[7:3];
                            end else begin
                                n.code = s.nack ? twm_pkg::SC_D_NACK[7:3]
                                    : twm_pkg::SC_D_ACK[7:3];
                            end
                        end
                    endcase
                end
            end

            // Data rises while the clock is high
            twm_pkg::PH_STOP: begin
                if (tick) begin
                    n.qc = s.qc + 2'd1;
                    case (s.qc)
                        2'd0: n.sda_oe_n = 1'b0;
                        2'd1: n.scl_oe_n = 1'b1;
                        2'd2: begin
                            if (scl_h) begin
                                n.sda_oe_n = 1'b1;
                            end else begin
                                n.qc = s.qc;
                            end
                        end
                        default: begin
                            n.own = 1'b0;
                            n.code = twm_pkg::SC_IDLE[7:3];
                            n.phase = s.sta ? twm_pkg::PH_WAIT
                                : twm_pkg::PH_IDLE;
                        end
                    endcase
                end
            end

            // Dispatch order: lost, stop, start, send
            twm_pkg::PH_HOLD: begin
                // Nothing moves on the wires while done is set
                if (!s.done) begin
                    n.qc = 2'd0;
                    if (s.code == twm_pkg::SC_ARB[7:3]) begin
                        n.code = twm_pkg::SC_IDLE[7:3];
                        n.phase = s.sta ? twm_pkg::PH_WAIT
                            : twm_pkg::PH_IDLE;
                    end else if (s.sto) begin
                        n.sto = 1'b0;
                        n.phase = twm_pkg::PH_STOP;
                    end else if (s.sta) begin
                        n.phase = twm_pkg::PH_START;
                    end else if (!s.recv_mode) begin
                        n.shift = s.data;
                        n.bitcnt = 3'd0;
                        n.phase = twm_pkg::PH_SEND;
                        if (s.addr_phase) begin
                            n.rw = s.data[0];
                        end
                    end
                end
            end

            default: n.phase = twm_pkg::PH_IDLE;
        endcase

        if (lost) begin
            n.scl_oe_n = 1'b1;
            n.sda_oe_n = 1'b1;
            n.own = 1'b0;
            n.code = twm_pkg::SC_ARB[7:3];
            n.done = 1'b1;
            n.phase = twm_pkg::PH_HOLD;
        end

        // Disabling the unit drops the bus at once, mid-byte if need be
        if (!n.en) begin
            n.phase = twm_pkg::PH_IDLE;
            n.scl_oe_n = 1'b1;
            n.sda_oe_n = 1'b1;
            n.own = 1'b0;
        end
    end

    // Reset loads constants only
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s <= twm_pkg::STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign WB_DAT_O = s.rdat;
    assign WB_ACK_O = s.ack;
    // Open drain: only the enables move
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE_N_O = s.scl_oe_n;
    assign SDA_OE_N_O = s.sda_oe_n;
endmodule // twm_master

// *** sim/twm_monitor.sv ***
// Concurrent checks on the ports of the two-wire master
`timescale 1ns/1ps
module twm_monitor (
    input wire logic CLK_SYS_I, // System clock
    input wire logic RSTN_I, // Reset, active low
    input wire logic WB_CYC_I, // Bus cycle
    input wire logic WB_STB_I, // Bus strobe
    input wire logic WB_WE_I, // Write enable
    input wire logic [3:0] WB_ADR_I, // Byte address
    input wire logic [31:0] WB_DAT_O, // Read data
    input wire logic WB_ACK_O, // Acknowledge
    input wire logic SCL_O, // Clock drive value
    input wire logic SCL_OE_N_O, // Clock drive enable
    input wire logic SDA_O, // Data drive value
    input wire logic SDA_OE_N_O // Data drive enable
);
    logic st_rd;
    assign st_rd = WB_ACK_O && !WB_WE_I && WB_ADR_I == twm_pkg::ADR_STAT;
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RSTN_I);
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_timely: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered in one cycle");
    a_ack_idle: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
        else $error("ack without a request");
    a_rdata_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_stat_low: assert property (st_rd |-> WB_DAT_O[2:0] == 3'h0)
        else $error("prescaler field not zero");
    a_stat_code: assert property (st_rd |-> WB_DAT_O[7:0] inside
        {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'hf8})
        else $error("unknown status code");
    a_open_drain: assert property (!SCL_O && !SDA_O)
        else $error("line driven high");
    a_oe_reset: assert property ($rose(RSTN_I) |-> SCL_OE_N_O && SDA_OE_N_O)
        else $error("line pulled just after reset");
    c_arb: cover property (st_rd && WB_DAT_O[7:0] == twm_pkg::SC_ARB);
    c_dnack: cover property (st_rd && WB_DAT_O[7:0] == twm_pkg::SC_D_NACK);
    c_rest: cover property (st_rd && WB_DAT_O[7:0] == twm_pkg::SC_RESTART);
endmodule // twm_monitor

// *** sim/twm_slave.sv ***
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
module twm_slave (
    input wire logic scl_i, // Resolved clock line
    input wire logic sda_i, // Resolved data line
    input wire logic nack_i, // Refuse the next byte
    output logic pull_o, // Pulls the data line low
    output logic [7:0] byte_o // Last byte taken
);
    logic [7:0] sh = 8'h00;
    int cnt = 0;
    initial pull_o = 1'b0;
    initial byte_o = 8'h00;
    // START restarts the byte framing
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) cnt = 0;
    end
    always @(posedge scl_i) begin
        if (cnt < 8) sh = {sh[6:0], sda_i};
        if (cnt == 8) byte_o = sh;
        cnt = cnt + 1;
    end
    // Ack driven only over the ninth clock, released at once after
    always @(negedge scl_i) begin
        pull_o = (cnt == 8) ? !nack_i : 1'b0;
        if (cnt == 9) cnt = 0;
    end
endmodule // twm_slave

// *** sim/testbench.sv ***
// Self-checking bench of the two-wire master transmitter
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0] d;
        logic ld;
        logic nk;
        logic rv;
        logic [7:0] ctl;
        logic [7:0] code;
    } twm_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rival = 1'b0, nk = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, scl, sda, pull, scl_oe_n, sda_oe_n;
    logic [7:0] sbyte;
    int error_cnt = 0, n_checks = 0;
    // Data, load/nack/rival, control write, awaited status
    twm_row_t rows [14] = '{
        {8'h00, 3'h0, 8'ha4, 8'h08},
        {8'ha0, 3'h4, 8'h84, 8'h18},
        {8'h5a, 3'h4, 8'h84, 8'h28},
        {8'h3c, 3'h6, 8'h84, 8'h30},
        {8'h00, 3'h0, 8'ha4, 8'h10},
        {8'ha2, 3'h6, 8'h84, 8'h20},
        {8'h81, 3'h4, 8'h84, 8'h28},
        {8'h00, 3'h0, 8'hb4, 8'h08},
        {8'ha1, 3'h4, 8'h84, 8'h40},
        {8'h00, 3'h0, 8'h94, 8'hf8},
        {8'h00, 3'h0, 8'ha4, 8'h08},
        {8'hfe, 3'h5, 8'h84, 8'h38},
        {8'h00, 3'h1, 8'h84, 8'hf8},
        {8'h00, 3'h0, 8'ha4, 8'h08}};
    // Pull-ups on both lines; only the master pulls the clock, any party may pull the data low
    assign scl = scl_oe_n;
    assign sda = sda_oe_n & !pull & !rival;
    always #20 clk = ~clk;
    twm_master u_twm_master (.CLK_SYS_I(clk), .RSTN_I(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SCL_I(scl),
        .SCL_O(), .SCL_OE_N_O(scl_oe_n), .SDA_I(sda), .SDA_O(),
        .SDA_OE_N_O(sda_oe_n));
    twm_slave u_twm_slave (.scl_i(scl), .sda_i(sda), .nack_i(nk),
        .pull_o(pull), .byte_o(sbyte));
    task automatic close_out;
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            error_cnt++;
            close_out();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // Polls status; a stale code would end the wait early
    task automatic wt(input logic [7:0] code);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            wb(1'b0, twm_pkg::ADR_STAT, 8'h00, q);
            n++;
        end while (q[7:0] !== code && n < 100);
        chk(q, {24'h0, code});
        // A wait that ran out was already counted above
        if (q[7:0] !== code) close_out();
    endtask
    task automatic step(input twm_row_t r);
        logic [31:0] q;
        nk <= r.nk;
        rival <= r.rv;
        if (r.ld) wb(1'b1, twm_pkg::ADR_DATA, r.d, q);
        wb(1'b1, twm_pkg::ADR_CTRL, r.ctl, q);
        wt(r.code);
        wb(1'b0, twm_pkg::ADR_CTRL, 8'h00, q);
        chk(q, {24'h0, r.code != 8'hf8, r.ctl[6:5], 2'h0, r.ctl[2:0]});
        if (r.ld && r.code != twm_pkg::SC_ARB)
            chk({24'h0, sbyte}, {24'h0, r.d});
        if (r.code == 8'hf8) chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    endtask
    initial begin
        logic [31:0] q;
        int n;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, twm_pkg::ADR_CTRL, 8'h00, q);
        chk(q, 32'h0);
        wb(1'b0, twm_pkg::ADR_STAT, 8'h00, q);
        chk(q, 32'hf8);
        wb(1'b0, twm_pkg::ADR_DATA, 8'h00, q);
        chk(q, 32'hff);
        wb(1'b0, 4'hc, 8'h00, q);
        chk(q, 32'h0);
        foreach (rows[i]) step(rows[i]);
        // Zero in step-done: no resume, lines must not move
        wb(1'b1, twm_pkg::ADR_CTRL, 8'h24, q);
        q = {30'h0, scl_oe_n, sda_oe_n};
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if ({30'h0, scl_oe_n, sda_oe_n} !== q) n++;
        end
        chk(32'(n), 32'h0);
        wb(1'b0, twm_pkg::ADR_CTRL, 8'h00, q);
        chk(q, 32'ha4);
        step({8'h00, 3'h0, 8'h94, 8'hf8});
        wb(1'b1, twm_pkg::ADR_DATA, 8'h77, q);
        wb(1'b0, twm_pkg::ADR_CTRL, 8'h00, q);
        chk(q, 32'h0c);
        wb(1'b0, twm_pkg::ADR_DATA, 8'h00, q);
        chk(q, 32'hfe);
        close_out();
    end
endmodule // testbench
bind twm_master twm_monitor u_twm_monitor (.CLK_SYS_I(CLK_SYS_I),
    .RSTN_I(RSTN_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .SCL_O(SCL_O), .SCL_OE_N_O(SCL_OE_N_O),
    .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O));
